/* include/qp_pkg.sv */
// shared constants, opcodes and helper functions for the quad pot command decoder
package qp_pkg;
   typedef logic [7:0] qp_byte_t; // one wiper or stored setting

   // system clock and nonvolatile write time
   localparam int CLK_HZ = 10_000_000; // clk rate
   localparam int T_WR_US = 5000; // write cycle time in us, plain default
   localparam int CLK_PER_US = CLK_HZ / 1_000_000; // cycles per us
   localparam int WR_CYC = T_WR_US * CLK_PER_US; // least time, exact multiple

   // frame layout, counted in serial bits
   localparam logic [4:0] HDR_LAST = 5'h0f; // edge that completes the header
   localparam logic [4:0] DATA_FIRST = 5'h10; // first data bit position
   localparam logic [4:0] DATA_LAST = 5'h17; // edge that completes the data byte
   localparam logic [4:0] CNT_MAX = 5'h1f; // bit counter saturates here

   // header field positions
   localparam int ID_MSB = 15; // fixed identity bits
   localparam int ID_LSB = 10;
   localparam int PIN_MSB = 9; // chip address pin bits
   localparam int PIN_LSB = 8;
   localparam int OP_MSB = 7; // opcode nibble
   localparam int OP_LSB = 4;
   localparam int SLOT_MSB = 3; // stored setting slot select
   localparam int SLOT_LSB = 2;
   localparam int POT_MSB = 1; // pot select
   localparam int POT_LSB = 0;

   // fixed identity bits 0,1,0,1,0,0
   localparam logic [5:0] DEV_ID = 6'h14;

   // opcodes
   localparam logic [3:0] OP_WR_STORED = 4'hc; // host byte into stored setting
   localparam logic [3:0] OP_RD_STAT = 4'h5; // status read
   localparam logic [3:0] OP_GLB_RECALL = 4'h1; // all stored -> all wipers
   localparam logic [3:0] OP_GLB_STORE = 4'h8; // all wipers -> all stored
   localparam logic [3:0] OP_STORE = 4'he; // one wiper -> stored
   localparam logic [3:0] OP_RECALL = 4'hd; // stored -> one wiper
   localparam logic [3:0] OP_STEP = 4'h2; // increment / decrement
   localparam logic [3:0] STAT_TAIL = 4'h1; // low nibble of status instruction
   localparam logic [1:0] FIELD_ZERO = 2'h0; // fields that must be zero

   // reset values
   localparam qp_byte_t WIPER_RST = 8'h80; // mid scale
   localparam qp_byte_t STORED_RST = 8'h80;
   localparam logic [9:0] POS_TOP = 10'h0ff; // wiper top position

   // binary to gray
   function automatic qp_byte_t bin2gray(input qp_byte_t b);
      return b ^ (b >> 1);
   endfunction

   // gray to binary
   function automatic qp_byte_t gray2bin(input qp_byte_t g);
      qp_byte_t b;
      b = g;
      for (int i = 6; i >= 0; i--) begin
         b[i] = b[i + 1] ^ g[i];
      end
      return b;
   endfunction
endpackage

/* rtl/qp_cmd_decoder.sv */
// serial command decoder of a quad digital potentiometer
// Notes on behaviour
// - write stored: id, pins, 1100, selects, data
// - status read returns seven zeros then busy
// - global recall loads all wipers from slot
// - global store copies all wipers, starts write
// - store copies one wiper, then nonvolatile write
// - recall loads one wiper, no nonvolatile write
// - step moves wiper per bit until release
// - programming starts only after frame ends
// - high bit steps up, low steps down
// - nonvolatile write lasts the write cycle time
module qp_cmd_decoder
   import qp_pkg::*;
#(
   parameter int WR_CYCLES = WR_CYC // write cycle length in clk cycles
)(
   // system clock and reset
   input wire logic clk,
   input wire logic nrst,
   // serial link, clocked by the host
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   output logic spi_so,
   output logic spi_so_oe,
   // chip address straps
   input wire logic chip_addr_pin_hi,
   input wire logic chip_addr_pin_lo,
   // wiper positions and status
   output qp_byte_t wiper_pos0,
   output qp_byte_t wiper_pos1,
   output qp_byte_t wiper_pos2,
   output qp_byte_t wiper_pos3,
   output logic write_in_progress_flag
);

   // saturating wiper move by net up and down counts
   function automatic qp_byte_t step_pos(input qp_byte_t pos, input qp_byte_t up,
                                         input qp_byte_t dn);
      logic [9:0] t;
      t = {2'h0, pos} + {2'h0, up};
      if (t < {2'h0, dn}) begin
         t = 10'h000;
      end else begin
         t = t - {2'h0, dn};
      end
      if (t > POS_TOP) begin
         t = POS_TOP;
      end
      return t[7:0];
   endfunction

   // ---------------- link side, spi_sck domain ----------------

   logic link_rst_q; // clk domain reset, held while nrst low
   logic [4:0] bit_cnt_q; // serial bits seen this frame
   logic [15:0] hdr_q; // identity, pins and instruction
   qp_byte_t data_q; // third byte
   logic got_hdr_q; // full header seen this frame
   logic got_data_q; // full data byte seen this frame
   logic addr_hit_q; // header matched identity and straps
   logic pin_hi_s1, pin_hi_s2; // strap synchroniser
   logic pin_lo_s1, pin_lo_s2;
   logic busy_s1, busy_s2; // busy flag synchroniser
   qp_byte_t up_bin_q, dn_bin_q; // step counts, binary
   qp_byte_t up_gray_q, dn_gray_q; // step counts, gray for crossing

   // frame release or system reset clears the per-frame counter
   wire frame_clr = spi_cs_n | link_rst_q;

   // header decode on the captured bits
   wire [15:0] hdr_d = {hdr_q[14:0], spi_si};
   wire id_match = hdr_d[ID_MSB:ID_LSB] == DEV_ID;
   wire pin_match = hdr_d[PIN_MSB:PIN_LSB] == {pin_hi_s2, pin_lo_s2};
   wire [3:0] op = hdr_q[OP_MSB:OP_LSB];
   wire [1:0] slot = hdr_q[SLOT_MSB:SLOT_LSB];
   wire [1:0] pot = hdr_q[POT_MSB:POT_LSB];
   wire hdr_ok = got_hdr_q & addr_hit_q;
   // steps count only once this frame's header is complete; the header
   // of the previous frame still stands at the first edge of a new one,
   // and would otherwise turn that first identity bit into a step
   wire past_hdr = bit_cnt_q > HDR_LAST; // header of this frame complete
   wire step_act = hdr_ok & past_hdr & (op == OP_STEP) & (slot == FIELD_ZERO);
   wire stat_act = hdr_ok & (hdr_q[OP_MSB:0] == {OP_RD_STAT, STAT_TAIL});
   wire out_win = (bit_cnt_q >= DATA_FIRST) & (bit_cnt_q <= DATA_LAST);

   // bit counter, cleared whenever chip select is high
   always_ff @(posedge spi_sck or posedge frame_clr) begin
      if (frame_clr) begin
         bit_cnt_q <= 5'h00;
      end else if (bit_cnt_q != CNT_MAX) begin
         bit_cnt_q <= bit_cnt_q + 5'h01;
      end
   end

   // strap and busy synchronisers, first stage read only by the second
   // sixteen header edges give both stages ample time before they are used
   always_ff @(posedge spi_sck) begin
      pin_hi_s1 <= chip_addr_pin_hi;
      pin_hi_s2 <= pin_hi_s1;
      pin_lo_s1 <= chip_addr_pin_lo;
      pin_lo_s2 <= pin_lo_s1;
      busy_s1 <= write_in_progress_flag;
      busy_s2 <= busy_s1;
   end

   // capture of header and data, msb first; held after the frame
   // so the clk side can read it once chip select is seen high
   always_ff @(posedge spi_sck or posedge link_rst_q) begin
      if (link_rst_q) begin
         hdr_q <= 16'h0000;
         data_q <= 8'h00;
         got_hdr_q <= 1'b0;
         got_data_q <= 1'b0;
         addr_hit_q <= 1'b0;
      end else begin
         if (bit_cnt_q <= HDR_LAST) begin
            hdr_q <= hdr_d;
         end else if (bit_cnt_q <= DATA_LAST) begin
            data_q <= {data_q[6:0], spi_si};
         end
         // flags drop on the first bit of the next frame
         if (bit_cnt_q == 5'h00) begin
            got_hdr_q <= 1'b0;
            got_data_q <= 1'b0;
         end
         if (bit_cnt_q == HDR_LAST) begin
            got_hdr_q <= 1'b1;
            addr_hit_q <= id_match & pin_match;
         end
         if (bit_cnt_q == DATA_LAST) begin
            got_data_q <= 1'b1;
         end
      end
   end

   // step counters; gray copies cross to clk, one bit changes per edge
   always_ff @(posedge spi_sck or posedge link_rst_q) begin
      if (link_rst_q) begin
         up_bin_q <= 8'h00;
         dn_bin_q <= 8'h00;
         up_gray_q <= 8'h00;
         dn_gray_q <= 8'h00;
      end else if (step_act) begin
         if (spi_si) begin
            up_bin_q <= up_bin_q + 8'h01;
            up_gray_q <= bin2gray(up_bin_q + 8'h01);
         end else begin
            dn_bin_q <= dn_bin_q + 8'h01;
            dn_gray_q <= bin2gray(dn_bin_q + 8'h01);
         end
      end
   end

   // status byte out on the falling edge, host samples on rising
   always_ff @(negedge spi_sck or posedge frame_clr) begin
      if (frame_clr) begin
         spi_so <= 1'b0;
         spi_so_oe <= 1'b0;
      end else if (stat_act & out_win) begin
         spi_so_oe <= 1'b1;
         spi_so <= (bit_cnt_q == DATA_LAST) ? busy_s2 : 1'b0;
      end else begin
         spi_so_oe <= 1'b0;
         spi_so <= 1'b0;
      end
   end

   // ---------------- core side, clk domain ----------------

   logic cs_s1, cs_s2, cs_s3; // chip select synchroniser and edge stage
   qp_byte_t up_s1, up_s2, dn_s1, dn_s2; // gray count synchronisers
   qp_byte_t up_seen_q, dn_seen_q; // counts already applied
   qp_byte_t wiper_q [4]; // wiper positions
   qp_byte_t stored_q [4][4]; // stored settings, [pot][slot]
   logic busy_q; // nonvolatile write running
   logic [31:0] wr_cnt_q; // write cycle countdown

   // frame end is the synced rising edge of chip select
   wire frame_end = cs_s2 & ~cs_s3;
   // header, flags and data are read here without synchronisers: they
   // stood still since the last sck edge, at least two clk edges ago
   wire cmd_ok = frame_end & hdr_ok;
   // nonvolatile commands are ignored while a write runs
   wire nv_ok = cmd_ok & ~busy_q;

   // one command per frame end; only the two global decodes check a fixed field, pot == FIELD_ZERO
   wire do_wr_stored = nv_ok & got_data_q & (op == OP_WR_STORED);
   wire do_glb_recall = cmd_ok & (op == OP_GLB_RECALL) & (pot == FIELD_ZERO);
   wire do_glb_store = nv_ok & (op == OP_GLB_STORE) & (pot == FIELD_ZERO);
   wire do_store = nv_ok & (op == OP_STORE);
   wire do_recall = cmd_ok & (op == OP_RECALL);
   wire nv_start = do_wr_stored | do_glb_store | do_store;

   // gray copies change one bit at a time, so a sample taken mid change
   // is either the old or the new count, never a mix of the two
   // net step counts since the last cycle
   wire qp_byte_t up_now = gray2bin(up_s2);
   wire qp_byte_t dn_now = gray2bin(dn_s2);
   wire qp_byte_t up_delta = up_now - up_seen_q;
   wire qp_byte_t dn_delta = dn_now - dn_seen_q;
   wire step_any = (up_delta != 8'h00) | (dn_delta != 8'h00);

   // link reset follows nrst so both sides leave reset together
   always_ff @(posedge clk) begin
      link_rst_q <= ~nrst;
   end

   // chip select and step count synchronisers
   always_ff @(posedge clk) begin
      cs_s1 <= spi_cs_n;
      cs_s2 <= cs_s1;
      up_s1 <= up_gray_q;
      up_s2 <= up_s1;
      dn_s1 <= dn_gray_q;
      dn_s2 <= dn_s1;
   end

   // edge stage and applied counts; link counters clear with nrst too
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cs_s3 <= 1'b1;
         up_seen_q <= 8'h00;
         dn_seen_q <= 8'h00;
      end else begin
         cs_s3 <= cs_s2;
         up_seen_q <= up_now;
         dn_seen_q <= dn_now;
      end
   end

   // wiper registers: recall, global recall and stepping
   // steps are applied as a net count each cycle, so a burst faster
   // than clk only settles the end position, which saturates at the ends
   always_ff @(posedge clk) begin
      if (!nrst) begin
         for (int i = 0; i < 4; i++) begin
            wiper_q[i] <= WIPER_RST;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (do_glb_recall) begin
               wiper_q[i] <= stored_q[i][slot];
            end else if (do_recall && pot == i[1:0]) begin
               wiper_q[i] <= stored_q[i][slot];
            end else if (step_any && pot == i[1:0]) begin
               wiper_q[i] <= step_pos(wiper_q[i], up_delta, dn_delta);
            end
         end
      end
   end

   // stored settings: host write, single and global store
   always_ff @(posedge clk) begin
      if (!nrst) begin
         for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 4; j++) begin
               stored_q[i][j] <= STORED_RST;
            end
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (do_wr_stored && pot == i[1:0]) begin
               stored_q[i][slot] <= data_q;
            end else if (do_glb_store) begin
               stored_q[i][slot] <= wiper_q[i];
            end else if (do_store && pot == i[1:0]) begin
               stored_q[i][slot] <= wiper_q[i];
            end
         end
      end
   end

   // write cycle timer, started only after chip select is released
   // busy spans exactly WR_CYCLES edges, the least write cycle time
   always_ff @(posedge clk) begin
      if (!nrst) begin
         busy_q <= 1'b0;
         wr_cnt_q <= 32'h0000_0000;
      end else if (nv_start) begin
         busy_q <= 1'b1;
         wr_cnt_q <= 32'(WR_CYCLES - 1);
      end else if (busy_q) begin
         if (wr_cnt_q == 32'h0000_0000) begin
            busy_q <= 1'b0;
         end else begin
            wr_cnt_q <= wr_cnt_q - 32'h0000_0001;
         end
      end
   end

   // outputs straight from registers
   assign wiper_pos0 = wiper_q[0];
   assign wiper_pos1 = wiper_q[1];
   assign wiper_pos2 = wiper_q[2];
   assign wiper_pos3 = wiper_q[3];
   assign write_in_progress_flag = busy_q;

endmodule

/* bench/qp_cmd_decoder_assertions.sv */
// port checker for the quad pot command decoder
module qp_cmd_decoder_assertions
   import qp_pkg::*;
#(
   parameter int WR_CYCLES = 20 // write cycle length in clk cycles
)(
   // system clock and reset
   input wire logic clk,
   input wire logic nrst,
   // serial link
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   input wire logic spi_so,
   input wire logic spi_so_oe,
   // straps, wipers and status
   input wire logic chip_addr_pin_hi,
   input wire logic chip_addr_pin_lo,
   input wire qp_byte_t wiper_pos0,
   input wire qp_byte_t wiper_pos1,
   input wire qp_byte_t wiper_pos2,
   input wire qp_byte_t wiper_pos3,
   input wire logic write_in_progress_flag
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] busy_q; // cycles the busy flag has stood
   logic [3:0] sent_q; // status bits already shown to the host
   // busy length counter, cleared whenever busy drops
   always_ff @(posedge clk) begin
      busy_q <= write_in_progress_flag ? busy_q + 16'h1 : 16'h0;
   end
   // count status bits; chip select high clears it at once
   always_ff @(posedge spi_sck or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         sent_q <= 4'h0;
      end else if (spi_so_oe) begin
         sent_q <= sent_q + 4'h1;
      end
   end
   // long enough idle that any command has already landed
   sequence s_idle;
      spi_cs_n [*7];
   endsequence
   // frame closed well before the flag may rise
   sequence s_frame_done;
      spi_cs_n && $past(spi_cs_n, 2);
   endsequence
   a_busy_length: assert property (@(posedge clk) disable iff (!nrst)
      $fell(write_in_progress_flag) |-> busy_q >= WR_CYCLES && busy_q <= WR_CYCLES + 1)
      else $error("busy flag held for the wrong time");
   a_busy_after_frame: assert property (@(posedge clk) disable iff (!nrst)
      $rose(write_in_progress_flag) |-> s_frame_done)
      else $error("busy rose inside a frame");
   a_busy_idle_quiet: assert property (@(posedge clk) disable iff (!nrst)
      s_idle |-> !$rose(write_in_progress_flag))
      else $error("busy rose with no command");
   a_wipers_idle_hold: assert property (@(posedge clk) disable iff (!nrst)
      s_idle |-> $stable({wiper_pos0, wiper_pos1, wiper_pos2, wiper_pos3}))
      else $error("wiper moved with link idle");
   a_oe_frame_only: assert property (@(posedge clk) disable iff (!nrst)
      spi_cs_n && $past(spi_cs_n) |-> !spi_so_oe)
      else $error("output driven outside a frame");
   a_so_low_off: assert property (@(posedge clk) disable iff (!nrst)
      !spi_so_oe && !$past(spi_so_oe) |-> !spi_so)
      else $error("serial out high while released");
   a_status_upper_zero: assert property (@(posedge spi_sck) disable iff (!nrst)
      spi_so_oe && sent_q < 4'h7 |-> !spi_so)
      else $error("status upper bit not zero");
   a_reset_quiet_out: assert property (@(posedge clk) disable iff (!nrst)
      !$past(nrst) |-> !write_in_progress_flag && !spi_so_oe && wiper_pos1 == WIPER_RST)
      else $error("outputs not at reset state");
endmodule

bind qp_cmd_decoder qp_cmd_decoder_assertions #(.WR_CYCLES(WR_CYCLES)) u_chk (.clk(clk),
   .nrst(nrst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so),
   .spi_so_oe(spi_so_oe), .chip_addr_pin_hi(chip_addr_pin_hi),
   .chip_addr_pin_lo(chip_addr_pin_lo), .wiper_pos0(wiper_pos0), .wiper_pos1(wiper_pos1),
   .wiper_pos2(wiper_pos2), .wiper_pos3(wiper_pos3),
   .write_in_progress_flag(write_in_progress_flag));

/* bench/qp_spi_host.sv */
// spi host model framing commands toward the quad pot decoder
module qp_spi_host
   import qp_pkg::*;
(
   // serial link toward the device
   output logic spi_sck,
   output logic spi_cs_n,
   output logic spi_si,
   input wire logic spi_so,
   input wire logic spi_so_oe,
   // bytes read back, last eight bits of a frame
   output qp_byte_t rx_byte
);
   timeunit 1ns;
   timeprecision 100ps;
   // idle link: clock parked low, select high
   initial begin
      spi_sck = 1'b0;
      spi_cs_n = 1'b1;
      spi_si = 1'b0;
      rx_byte = 8'h00;
   end
   // one frame, msb first; clock runs only inside it
   task automatic xfer(input logic [31:0] bits, input int n);
      spi_cs_n = 1'b0;
      #100;
      for (int i = 0; i < n; i++) begin
         spi_si = bits[31 - i];
         #7.5 spi_sck = 1'b1;
         // released line shows the inverse, never a stale bit
         rx_byte = {rx_byte[6:0], spi_so_oe ? spi_so : ~rx_byte[0]};
         #7.5 spi_sck = 1'b0;
      end
      #7.5 spi_cs_n = 1'b1;
      spi_si = ~spi_si;
   endtask
endmodule

/* bench/qp_cmd_decoder_test.sv */
// self-checking bench for the quad pot command decoder
`define QP_CHECK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin miscompares++; \
   $display("Error %s expected %h seen %h", nm, e, s); end end
module qp_cmd_decoder_test
   import qp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int WRC = 40; // shortened write cycle
   typedef struct {int k; qp_byte_t v;} qp_note_s; // probe index and expected value
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic probe = 1'b0; // tells the monitor that results have landed
   wire logic sck, cs_n, si, so, so_oe, busy;
   qp_byte_t wp [4]; // wipers 0..3
   qp_byte_t rx, d, e0, s;
   qp_note_s notes [$];
   int miscompares = 0;
   int checks_done = 0;
   int cyc = 0;
   always #50 clk = ~clk;
   qp_cmd_decoder #(.WR_CYCLES(WRC)) u_qp_cmd_decoder (.clk(clk), .nrst(nrst), .spi_sck(sck),
      .spi_cs_n(cs_n), .spi_si(si), .spi_so(so), .spi_so_oe(so_oe), .chip_addr_pin_hi(1'b1),
      .chip_addr_pin_lo(1'b0), .wiper_pos0(wp[0]), .wiper_pos1(wp[1]), .wiper_pos2(wp[2]),
      .wiper_pos3(wp[3]), .write_in_progress_flag(busy));
   qp_spi_host u_qp_spi_host (.spi_sck(sck), .spi_cs_n(cs_n), .spi_si(si), .spi_so(so),
      .spi_so_oe(so_oe), .rx_byte(rx));
   // probe 0..3 wipers, 4 busy, 5 last byte read
   function automatic qp_byte_t obs(input int k);
      return k < 4 ? wp[k] : k == 4 ? {7'h00, busy} : rx;
   endfunction
   // monitor: oldest note first against what is seen
   always @(posedge clk) begin
      if (probe) begin
         while (notes.size() > 0) begin
            `QP_CHECK($sformatf("probe %0d", notes[0].k), notes[0].v, obs(notes[0].k))
            void'(notes.pop_front());
         end
      end
   end
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   task automatic note(input int k, input qp_byte_t v);
      notes.push_back('{k, v});
   endtask
   task automatic look();
      repeat (2) @(posedge clk);
      #1 probe = 1'b1;
      @(posedge clk);
      #1 probe = 1'b0;
   endtask
   function automatic logic [15:0] hdr(input logic [3:0] op, input logic [1:0] sl, po,
      input logic [1:0] st = 2'h2);
      return {6'h14, st, op, sl, po};
   endfunction
   // frame then an idle gap longer than the decoder needs
   task automatic frm(input logic [15:0] h, input qp_byte_t dt, input int n);
      u_qp_spi_host.xfer({h, dt, 8'h00}, n);
      repeat (6) @(posedge clk);
      #1;
   endtask
   // bounded wait for the write cycle to end
   task automatic drain();
      for (int i = 0; i < 100 && busy !== 1'b0; i++) @(posedge clk);
      #1;
   endtask
   task automatic stp(input logic [1:0] po, input qp_byte_t b, inout qp_byte_t e);
      frm(hdr(OP_STEP, 2'h0, po), b, 24);
      for (int i = 0; i < 8; i++) e = b[i] ? e + 8'h1 : e - 8'h1;
   endtask
   task automatic tally_and_finish();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      d = qp_byte_t'($urandom(20));
      repeat (12) @(posedge clk);
      #1 nrst = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      for (int k = 0; k < 5; k++) note(k, k < 4 ? WIPER_RST : 8'h00);
      look();
      d = qp_byte_t'($urandom);
      frm(hdr(OP_WR_STORED, 2'h1, 2'h2), d, 24);
      note(4, 8'h01);
      frm(hdr(OP_RD_STAT, 2'h0, 2'h1), 8'h00, 24);
      note(5, 8'h01);
      look();
      // second write while busy must be dropped
      frm(hdr(OP_WR_STORED, 2'h1, 2'h2), ~d, 24);
      look();
      drain();
      frm(hdr(OP_RD_STAT, 2'h0, 2'h1), 8'h00, 24);
      note(5, 8'h00);
      look();
      frm(hdr(OP_RECALL, 2'h1, 2'h2, 2'h1), 8'h00, 16);
      note(2, WIPER_RST);
      look();
      frm(hdr(OP_RECALL, 2'h1, 2'h2), 8'h00, 16);
      note(2, d);
      look();
      e0 = WIPER_RST;
      stp(2'h0, qp_byte_t'($urandom), e0);
      note(0, e0);
      frm(hdr(OP_STORE, 2'h3, 2'h0), 8'h00, 16);
      note(4, 8'h01);
      look();
      drain();
      frm(hdr(OP_GLB_STORE, 2'h2, 2'h0), 8'h00, 16);
      note(4, 8'h01);
      look();
      drain();
      s = e0;
      stp(2'h0, 8'h00, s);
      note(0, s);
      look();
      frm(hdr(OP_RECALL, 2'h3, 2'h0), 8'h00, 16);
      note(0, e0);
      look();
      s = e0;
      stp(2'h0, 8'h00, s);
      frm(hdr(OP_GLB_RECALL, 2'h2, 2'h0), 8'h00, 16);
      for (int k = 0; k < 4; k++) note(k, k == 0 ? e0 : k == 2 ? d : WIPER_RST);
      look();
      tally_and_finish();
   end
endmodule
